// file: src/cla_pkg.sv
// Purpose: shared constants and types for the configurable logic array
// Assumes: configuration bits arrive as static plain ports
// Notes: one system clock; the four pin clocks are sampled and edge detected
// Overview of operation
// - four blocks, matrix fed by 64 pins, 2 inputs
// - four clock pins also usable as inputs
// - block holds 64 terms, allocator, 16 cells
// - matrix delivers 26 signals to each block
// - matrix reaches every block and every input
// - block returns 16 cell and 16 pin feedbacks
// - six special terms: four enable, reset, preset
// - pin cells form two banks of eight
// - reset and preset act on whole block
// - at most twelve terms per macrocell
// - macrocell n uses clusters n-1, n, n+1
// - registered or combinatorial, selectable polarity
// - cell feedback exists in both configurations
// - flip-flop acts as D or T type
// - each flip-flop picks one of four clocks
// - registers capture on rising clock edge
// - driver always on, always off, or term
// - term control uses own bank's two terms
// - buried cell feeds matrix, pin stays input
// - pins serve as output, input, bidirectional, bus
package cla_pkg;
  localparam int CLA_BLOCKS     = 4;   // logic blocks
  localparam int CLA_CELLS      = 16;  // macrocells per block
  localparam int CLA_PINS       = 64;  // bidirectional pins
  localparam int CLA_DED_IN     = 2;   // dedicated inputs
  localparam int CLA_CLKS       = 4;   // clock-capable pins
  localparam int CLA_BLK_IN     = 26;  // matrix signals per block
  localparam int CLA_TERMS      = 64;  // logic terms per block
  localparam int CLA_CLUSTER    = 4;   // terms per cluster
  localparam int CLA_MAX_TERMS  = 12;  // most terms into one cell
  localparam int CLA_BANK       = 8;   // pin cells per enable bank
  // matrix source vector: pins, cell feedback, dedicated, clock pins
  localparam int CLA_SRC_W      = CLA_PINS + CLA_PINS + CLA_DED_IN + CLA_CLKS;
  localparam int CLA_SEL_W      = $clog2(CLA_SRC_W);
  localparam int CLA_LIT_W      = 2 * CLA_BLK_IN;  // true and complement
  localparam logic [1:0] CLA_OE_ON  = 2'h1;  // driver always enabled
  localparam logic [1:0] CLA_OE_OFF = 2'h0;  // driver always disabled
  localparam logic [1:0] CLA_OE_T0  = 2'h2;  // bank term 0
  localparam logic [1:0] CLA_OE_T1  = 2'h3;  // bank term 1

  // per-macrocell configuration
  typedef struct packed {
    logic       registered;  // 1: flip-flop output, 0: combinatorial
    logic       invert;      // output polarity
    logic       toggle;      // 1: T type, 0: D type
    logic [1:0] clk_sel;     // global clock choice
    logic [1:0] oe_mode;     // pin driver mode
    logic [2:0] clus_en;     // bit 0: cluster n-1, bit 1: n, bit 2: n+1
  } cla_cell_cfg_s;

  // pin pad triple
  typedef struct packed {
    logic [CLA_PINS-1:0] din;
    logic [CLA_PINS-1:0] dout;
    logic [CLA_PINS-1:0] oe;
  } cla_pad_s;
endpackage : cla_pkg

// file: src/cla_macrocell.sv
// Purpose: one macrocell with its flip-flop and output selection
// Assumes: clk_rise is a one-cycle pulse on the selected pin clock edge
// Notes: async reset/preset modelled as block-wide synchronous overrides
`timescale 1ns/10ps
module cla_macrocell
  import cla_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // control
  input  wire cla_cell_cfg_s cfg,
  input  wire logic [3:0]    clk_rise,   // rising edge pulses per pin clock
  input  wire logic          blk_reset,  // block reset term
  input  wire logic          blk_preset, // block preset term
  input  wire logic          sum,        // allocated term sum
  // result
  output logic               q_out       // registered; also cell feedback
);
  typedef struct packed {
    logic ff;   // stored bit
    logic out;  // polarity-corrected output
  } cla_mc_st_s;

  cla_mc_st_s st;       // present state
  cla_mc_st_s next_st;  // next state
  logic       edge_hit; // selected clock rose

  // choose state update; reset beats preset so a clash is well defined
  always_comb begin
    next_st  = st;
    edge_hit = clk_rise[cfg.clk_sel];
    if (blk_reset) begin
      next_st.ff = 1'b0;
    end else if (blk_preset) begin
      next_st.ff = 1'b1;
    end else if (edge_hit) begin
      next_st.ff = cfg.toggle ? (st.ff ^ sum) : sum;
    end
    // both modes land here, so feedback exists either way
    next_st.out = (cfg.registered ? next_st.ff : sum) ^ cfg.invert;
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.out;

  property p_reset_wins;
    @(posedge clk) disable iff (!nrst)
      (blk_reset && blk_preset) |=> (st.ff == 1'b0);
  endproperty
  a_reset_wins: assert property (p_reset_wins)
    else $error("reset did not win over preset");

  property p_toggle;
    @(posedge clk) disable iff (!nrst)
      (!blk_reset && !blk_preset && edge_hit && cfg.toggle && sum)
        |=> (st.ff != $past(st.ff));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("T flip-flop failed to toggle");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
      (!blk_reset && !blk_preset && !edge_hit) |=> $stable(st.ff);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flip-flop changed without clock edge");

  property p_dtype;
    @(posedge clk) disable iff (!nrst)
      (!blk_reset && !blk_preset && edge_hit && !cfg.toggle) |=> (st.ff == $past(sum));
  endproperty
  a_dtype: assert property (p_dtype)
    else $error("D flip-flop did not capture");
endmodule : cla_macrocell

// file: src/cla_block.sv
// Purpose: four-block configurable logic array with routing matrix
// Assumes: configuration ports are static; pin signals are asynchronous
// Notes: every pin, dedicated input and clock pin passes two flip-flops
`timescale 1ns/10ps
module cla_block
  import cla_pkg::*;
#(
  parameter int BLOCKS = CLA_BLOCKS,
  parameter int CELLS  = CLA_CELLS
)(
  // clock and reset
  input  wire logic                                   clk,
  input  wire logic                                   nrst,
  // pins from the board
  input  wire logic [CLA_PINS-1:0]                    pin_in,
  input  wire logic [CLA_DED_IN-1:0]                  ded_in,
  input  wire logic [CLA_CLKS-1:0]                    clk_pin,
  // pins to the board
  output logic [CLA_PINS-1:0]                         pin_out,
  output logic [CLA_PINS-1:0]                         pin_oe,
  // matrix selection: per block, per input, a source index
  input  wire logic [BLOCKS-1:0][CLA_BLK_IN-1:0][CLA_SEL_W-1:0] route_sel,
  // logic array: per block term, literal mask (true then complement)
  input  wire logic [BLOCKS-1:0][CLA_TERMS-1:0][CLA_LIT_W-1:0]  term_mask,
  // special terms: 0..3 enable, 4 reset, 5 preset
  input  wire logic [BLOCKS-1:0][5:0][CLA_LIT_W-1:0]            spec_mask,
  // macrocell configuration
  input  wire cla_cell_cfg_s [BLOCKS-1:0][CELLS-1:0]            cell_cfg
);
  // synchronised pin state, one struct
  typedef struct packed {
    logic [CLA_PINS-1:0]   pin_s1;  // first stage, read only by second
    logic [CLA_PINS-1:0]   pin_s2;
    logic [CLA_DED_IN-1:0] ded_s1;
    logic [CLA_DED_IN-1:0] ded_s2;
    logic [CLA_CLKS-1:0]   ck_s1;
    logic [CLA_CLKS-1:0]   ck_s2;
    logic [CLA_CLKS-1:0]   ck_s3;   // previous clock level for edges
    logic [CLA_PINS-1:0]   oe;      // registered driver enables
  } cla_top_st_s;

  cla_top_st_s                          st;          // present state
  cla_top_st_s                          next_st;     // next state
  logic [CLA_PINS-1:0]                  cell_fb;     // all cell outputs
  logic [CLA_SRC_W-1:0]                 src;         // matrix source vector
  logic [CLA_CLKS-1:0]                  clk_rise;    // pin clock rising pulses
  logic [BLOCKS-1:0][CLA_BLK_IN-1:0]    blk_in;      // matrix outputs
  logic [BLOCKS-1:0][CLA_TERMS-1:0]     term;        // logic term values
  logic [BLOCKS-1:0][5:0]               spec;        // special term values
  logic [BLOCKS-1:0][CELLS-1:0]         sum;         // allocated sums
  logic [BLOCKS-1:0][CELLS-1:0]         sum_terms_ok;// cell uses at most 12
  logic [CLA_PINS-1:0]                  oe_cfg_off;  // pins configured never to drive
  logic [CLA_PINS-1:0]                  oe_cfg_on;   // pins configured always to drive

  // source vector: pin feedback, cell feedback, dedicated and clock inputs
  assign src = {st.ck_s2, st.ded_s2, cell_fb, st.pin_s2};

  // rising edge of each pin clock, taken after synchronisation
  assign clk_rise = st.ck_s2 & ~st.ck_s3;

  // next state: synchronisers and enable decode
  always_comb begin
    next_st        = st;
    next_st.pin_s1 = pin_in;
    next_st.pin_s2 = st.pin_s1;
    next_st.ded_s1 = ded_in;
    next_st.ded_s2 = st.ded_s1;
    next_st.ck_s1  = clk_pin;
    next_st.ck_s2  = st.ck_s1;
    next_st.ck_s3  = st.ck_s2;
    for (int b = 0; b < BLOCKS; b++) begin
      for (int c = 0; c < CELLS; c++) begin
        // bank picks enable terms 0,1 or 2,3
        automatic int bk = (c / CLA_BANK) * 2;
        unique case (cell_cfg[b][c].oe_mode)
          CLA_OE_OFF: next_st.oe[b*CELLS+c] = 1'b0;
          CLA_OE_ON:  next_st.oe[b*CELLS+c] = 1'b1;
          CLA_OE_T0:  next_st.oe[b*CELLS+c] = spec[b][bk];
          CLA_OE_T1:  next_st.oe[b*CELLS+c] = spec[b][bk+1];
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // matrix, array and allocator for each block
  genvar gb, gi, gt, gc;
  generate
    for (gb = 0; gb < BLOCKS; gb++) begin : g_blk
      // any source reaches any block input
      for (gi = 0; gi < CLA_BLK_IN; gi++) begin : g_in
        assign blk_in[gb][gi] = (route_sel[gb][gi] < CLA_SEL_W'(CLA_SRC_W)) ?
                                src[route_sel[gb][gi]] : 1'b0;
      end
      // literals: true then complement
      logic [CLA_LIT_W-1:0] lit;
      assign lit = {~blk_in[gb], blk_in[gb]};
      // a term is the AND of its masked literals
      for (gt = 0; gt < CLA_TERMS; gt++) begin : g_term
        assign term[gb][gt] = &(lit | ~term_mask[gb][gt]);
      end
      for (gt = 0; gt < 6; gt++) begin : g_spec
        assign spec[gb][gt] = &(lit | ~spec_mask[gb][gt]);
      end
      // allocator: neighbouring clusters only, edges clipped
      for (gc = 0; gc < CELLS; gc++) begin : g_cell
        logic [CLA_CLUSTER-1:0] cl_lo;
        logic [CLA_CLUSTER-1:0] cl_mid;
        logic [CLA_CLUSTER-1:0] cl_hi;
        logic [3:0]             n_used;
        assign cl_mid = term[gb][gc*CLA_CLUSTER +: CLA_CLUSTER];
        if (gc == 0) begin : g_first
          assign cl_lo = '0;
        end else begin : g_lo
          assign cl_lo = term[gb][(gc-1)*CLA_CLUSTER +: CLA_CLUSTER];
        end
        if (gc == CELLS-1) begin : g_last
          assign cl_hi = '0;
        end else begin : g_hi
          assign cl_hi = term[gb][(gc+1)*CLA_CLUSTER +: CLA_CLUSTER];
        end
        // three clusters of four cap the sum at twelve terms
        assign sum[gb][gc] = (cell_cfg[gb][gc].clus_en[0] & (|cl_lo)) |
                             (cell_cfg[gb][gc].clus_en[1] & (|cl_mid)) |
                             (cell_cfg[gb][gc].clus_en[2] & (|cl_hi));
        assign n_used = 4'(CLA_CLUSTER) * 4'(cell_cfg[gb][gc].clus_en[0] +
                        cell_cfg[gb][gc].clus_en[1] + cell_cfg[gb][gc].clus_en[2]);
        assign sum_terms_ok[gb][gc] = (n_used <= 4'(CLA_MAX_TERMS));
        cla_macrocell cla_macrocell_inst (
          .clk        (clk),
          .nrst       (nrst),
          .cfg        (cell_cfg[gb][gc]),
          .clk_rise   (clk_rise),
          .blk_reset  (spec[gb][4]),
          .blk_preset (spec[gb][5]),
          .sum        (sum[gb][gc]),
          .q_out      (cell_fb[gb*CELLS+gc])
        );
      end
    end
  endgenerate

  // pin drive; pin input path stays live whatever the enable does
  assign pin_out = cell_fb;
  assign pin_oe  = st.oe;

  // configured driver modes per pin, read only by the enable checks;
  // cleared first so a short array never leaves a bit undriven
  always_comb begin
    oe_cfg_off = '0;
    oe_cfg_on  = '0;
    for (int b = 0; b < BLOCKS; b++) begin
      for (int c = 0; c < CELLS; c++) begin
        oe_cfg_off[b*CELLS+c] = (cell_cfg[b][c].oe_mode == CLA_OE_OFF);
        oe_cfg_on[b*CELLS+c]  = (cell_cfg[b][c].oe_mode == CLA_OE_ON);
      end
    end
  end

  property p_twelve;
    @(posedge clk) disable iff (!nrst)
      &sum_terms_ok;
  endproperty
  a_twelve: assert property (p_twelve)
    else $error("macrocell fed by more than twelve terms");

  // every driver configured off stays off, whatever its bank terms do
  property p_oe_off;
    @(posedge clk) disable iff (!nrst)
      (|oe_cfg_off) |=> ((pin_oe & $past(oe_cfg_off)) == '0);
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("disabled driver is enabled");

  // every driver configured on drives one edge after the decode
  property p_oe_on;
    @(posedge clk) disable iff (!nrst)
      (|oe_cfg_on) |=> ((~pin_oe & $past(oe_cfg_on)) == '0);
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("enabled driver is not driving");

  property p_oe_bank;
    @(posedge clk) disable iff (!nrst)
      (cell_cfg[0][CLA_BANK].oe_mode == CLA_OE_T0) |=> (pin_oe[CLA_BANK] == $past(spec[0][2]));
  endproperty
  a_oe_bank: assert property (p_oe_bank)
    else $error("upper bank did not use its own enable term");

  property p_clk_sync;
    @(posedge clk) disable iff (!nrst)
      $rose(clk_pin[0]) ##1 $stable(clk_pin[0]) |-> ##1 clk_rise[0];
  endproperty
  a_clk_sync: assert property (p_clk_sync)
    else $error("pin clock edge not seen");
endmodule : cla_block

// file: verification/cla_board.sv
// Purpose: board logic on the far side of the bidirectional pins
// Assumes: the bench asks for a drive through drv_en and drv_val
// Notes: no pull resistor, so a released pin wanders every cycle
`timescale 1ns/10ps
module cla_board
  import cla_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // device side of the pins
  input  wire logic [CLA_PINS-1:0] pin_out,
  input  wire logic [CLA_PINS-1:0] pin_oe,
  // bench requests
  input  wire logic [CLA_PINS-1:0] drv_val,
  input  wire logic [CLA_PINS-1:0] drv_en,
  // resolved wire level
  output logic [CLA_PINS-1:0]      pin_lvl
);
  logic [CLA_PINS-1:0] last;  // level seen at the previous edge
  logic [CLA_PINS-1:0] own;   // pins the board really drives

  // board backs off wherever the device drives, so no contention
  assign own = drv_en & ~pin_oe;

  // wire level: device, else board, else inverse of last level
  assign pin_lvl = (pin_oe & pin_out) | (own & drv_val) | (~pin_oe & ~own & ~last);

  // remember the level so a floating pin never holds its value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last <= '0;
    end else begin
      last <= pin_lvl;
    end
  end
endmodule : cla_board

// file: verification/cla_block_tb.sv
// Purpose: self-checking bench for the configurable logic array
// Assumes: configuration is static and set before reset is released
// Notes: pin paths pass synchronisers, so checks poll a few cycles
`timescale 1ns/10ps
module cla_block_tb
  import cla_pkg::*;
;
  localparam logic [CLA_LIT_W-1:0] NEVER = 52'h4000001;  // a and not a
  logic                                                 clk, nrst;
  logic [CLA_PINS-1:0]                                  pin_lvl, pin_out, pin_oe;
  logic [CLA_PINS-1:0]                                  drv_val, drv_en;
  logic [CLA_DED_IN-1:0]                                ded_in;
  logic [CLA_CLKS-1:0]                                  clk_pin;
  logic [CLA_BLOCKS-1:0][CLA_BLK_IN-1:0][CLA_SEL_W-1:0] route_sel;
  logic [CLA_BLOCKS-1:0][CLA_TERMS-1:0][CLA_LIT_W-1:0]  term_mask;
  logic [CLA_BLOCKS-1:0][5:0][CLA_LIT_W-1:0]            spec_mask;
  cla_cell_cfg_s [CLA_BLOCKS-1:0][CLA_CELLS-1:0]        cell_cfg;
  int                                                   fails, total_checks;

  cla_block cla_block_inst (.clk(clk), .nrst(nrst), .pin_in(pin_lvl), .ded_in(ded_in),
    .clk_pin(clk_pin), .pin_out(pin_out), .pin_oe(pin_oe), .route_sel(route_sel),
    .term_mask(term_mask), .spec_mask(spec_mask), .cell_cfg(cell_cfg));
  cla_board cla_board_inst (.clk(clk), .nrst(nrst), .pin_out(pin_out), .pin_oe(pin_oe),
    .drv_val(drv_val), .drv_en(drv_en), .pin_lvl(pin_lvl));

  // 100 MHz system clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(string name, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s exp=%b got=%b", name, exp, got);
    end
  endtask : chk

  // poll one output bit (sel high: enable) for up to 8 cycles
  task automatic wait_bit(string name, logic sel, int idx, logic exp);
    logic got;
    for (int n = 0; n < 8; n++) begin
      @(negedge clk);
      got = sel ? pin_oe[idx] : pin_out[idx];
      if (got === exp) break;
    end
    chk(name, exp, got);
  endtask : wait_bit

  // move a clock pin, then give syncs and edge detect time to act
  task automatic set_clk(int k, logic v);
    @(negedge clk);
    clk_pin[k] = v;
    repeat (5) @(negedge clk);
  endtask : set_clk

  function automatic cla_cell_cfg_s mk(logic rg, logic inv, logic tg, logic [1:0] cs,
                                       logic [1:0] oe, logic [2:0] cl);
    mk = '{registered: rg, invert: inv, toggle: tg, clk_sel: cs, oe_mode: oe, clus_en: cl};
  endfunction : mk

  task automatic t_static;
    wait_bit("oe_on", 1'h1, 0, 1'h1);
    chk("oe_off", 1'h0, pin_oe[3]);
    chk("inv_out", 1'h1, pin_out[7]);
    chk("no_cluster", 1'h0, pin_out[15]);
  endtask : t_static

  // pin 40 belongs to a buried cell, so it serves as an input
  task automatic t_comb;
    @(negedge clk);
    drv_val[40] = 1'h1;
    wait_bit("comb", 1'h0, 0, 1'h1);
    wait_bit("clus_lo", 1'h0, 5, 1'h1);
    wait_bit("clus_hi", 1'h0, 6, 1'h0);
    wait_bit("fb_hi", 1'h0, 16, 1'h1);
    chk("no_wrap", 1'h0, pin_out[15]);
    @(negedge clk);
    drv_val[40] = 1'h0;
    wait_bit("comb_lo", 1'h0, 0, 1'h0);
    wait_bit("fb_lo", 1'h0, 16, 1'h0);
    wait_bit("clus_hi_lo", 1'h0, 6, 1'h1);
  endtask : t_comb

  task automatic t_dff;
    drv_val[40] = 1'h1;
    repeat (5) @(negedge clk);
    chk("d_idle", 1'h0, pin_out[1]);
    set_clk(0, 1'h1);
    chk("d_rise", 1'h1, pin_out[1]);
    drv_val[40] = 1'h0;
    set_clk(0, 1'h0);
    chk("d_fall", 1'h1, pin_out[1]);
    chk("t_other_clk", 1'h0, pin_out[2]);
    set_clk(0, 1'h1);
    chk("d_zero", 1'h0, pin_out[1]);
    set_clk(0, 1'h0);
  endtask : t_dff

  task automatic t_tff;
    set_clk(1, 1'h1);
    chk("t_one", 1'h1, pin_out[2]);
    set_clk(1, 1'h0);
    set_clk(1, 1'h1);
    chk("t_two", 1'h0, pin_out[2]);
    set_clk(1, 1'h0);
  endtask : t_tff

  task automatic t_rst;
    @(negedge clk);
    ded_in = 2'h2;
    wait_bit("pre_d", 1'h0, 1, 1'h1);
    wait_bit("pre_t", 1'h0, 2, 1'h1);
    ded_in = 2'h3;
    wait_bit("both_d", 1'h0, 1, 1'h0);
    wait_bit("both_t", 1'h0, 2, 1'h0);
    ded_in = 2'h0;
  endtask : t_rst

  // clock pin 3 serves as a plain input feeding the enable terms
  task automatic t_oe;
    set_clk(3, 1'h1);
    chk("oe_t0", 1'h1, pin_oe[4]);
    chk("oe_t1_hi", 1'h1, pin_oe[9]);
    chk("oe_bank", 1'h0, pin_oe[8]);
    set_clk(3, 1'h0);
    chk("oe_t0_lo", 1'h0, pin_oe[4]);
  endtask : t_oe

  // mid-run reset: outputs drop while held, enables return after release
  task automatic t_nrst;
    @(negedge clk);
    nrst = 1'h0;
    @(negedge clk);
    chk("rst_oe", 1'h0, pin_oe[0]);
    chk("rst_out", 1'h0, pin_out[7]);
    nrst = 1'h1;
    wait_bit("rst_oe_back", 1'h1, 0, 1'h1);
    wait_bit("rst_out_back", 1'h0, 7, 1'h1);
  endtask : t_nrst

  // main sequence: static configuration, reset, scenarios
  initial begin
    nrst = 1'h0;
    clk_pin = '0;
    ded_in = '0;
    drv_val = '0;
    drv_en = '0;
    drv_en[40] = 1'h1;
    route_sel = '1;
    cell_cfg = '0;
    for (int b = 0; b < CLA_BLOCKS; b++) begin
      for (int t = 0; t < CLA_TERMS; t++) term_mask[b][t] = NEVER;
      for (int t = 0; t < 6; t++) spec_mask[b][t] = NEVER;
    end
    route_sel[0][0] = 8'h28;
    route_sel[0][1] = 8'h80;
    route_sel[0][2] = 8'h81;
    route_sel[0][3] = 8'h85;
    route_sel[1][0] = 8'h40;
    term_mask[0][0] = 52'h1;
    term_mask[0][4] = 52'h1;
    term_mask[0][8] = '0;
    term_mask[0][16] = 52'h1;
    term_mask[0][28] = 52'h4000000;
    term_mask[1][0] = 52'h1;
    spec_mask[0][0] = 52'h8;
    spec_mask[0][3] = 52'h8;
    spec_mask[0][4] = 52'h2;
    spec_mask[0][5] = 52'h4;
    cell_cfg[0][0] = mk(1'h0, 1'h0, 1'h0, 2'h0, CLA_OE_ON, 3'h2);
    cell_cfg[0][1] = mk(1'h1, 1'h0, 1'h0, 2'h0, CLA_OE_ON, 3'h2);
    cell_cfg[0][2] = mk(1'h1, 1'h0, 1'h1, 2'h1, CLA_OE_ON, 3'h2);
    cell_cfg[0][4] = mk(1'h0, 1'h0, 1'h0, 2'h0, CLA_OE_T0, 3'h0);
    cell_cfg[0][5] = mk(1'h0, 1'h0, 1'h0, 2'h0, CLA_OE_OFF, 3'h1);
    cell_cfg[0][6] = mk(1'h0, 1'h0, 1'h0, 2'h0, CLA_OE_OFF, 3'h4);
    cell_cfg[0][7] = mk(1'h0, 1'h1, 1'h0, 2'h0, CLA_OE_OFF, 3'h0);
    cell_cfg[0][8] = mk(1'h0, 1'h0, 1'h0, 2'h0, CLA_OE_T0, 3'h0);
    cell_cfg[0][9] = mk(1'h0, 1'h0, 1'h0, 2'h0, CLA_OE_T1, 3'h0);
    cell_cfg[0][15] = mk(1'h0, 1'h0, 1'h0, 2'h0, CLA_OE_OFF, 3'h4);
    cell_cfg[1][0] = mk(1'h0, 1'h0, 1'h0, 2'h0, CLA_OE_OFF, 3'h2);
    repeat (5) @(negedge clk);
    nrst = 1'h1;
    t_static;
    t_comb;
    t_dff;
    t_tff;
    t_rst;
    t_oe;
    t_nrst;
    end_sim;
  end

  // watchdog: the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    end_sim;
  end
endmodule : cla_block_tb
